// [pkg/tdt_defines.svh]
// Constants of the dual channel tamper detect block
`ifndef TDT_DEFINES_SVH
`define TDT_DEFINES_SVH
// ==========================================================
// Clock and timing
// Core clock rate in kHz (25 MHz)
`define TDT_CLK_KHZ 25000
// Sampling period of normally closed inputs in ms (1 Hz)
`define TDT_SAMPLE_PERIOD_MS 1000
// Pull window per sample in cycles, covers pull settle and the synchroniser
`define TDT_SAMPLE_WIN_CYC 3'h6
// ==========================================================
// User RAM
// Number of bytes of user RAM
`define TDT_RAM_BYTES 128
// Address width of the user RAM
`define TDT_RAM_AW 7
// Last RAM address, end of a wipe
`define TDT_RAM_LAST 7'h7f
// Value returned by reads while the RAM is locked after a wipe
`define TDT_RAM_INVALID 8'hff
// Value written by a wipe
`define TDT_RAM_WIPE_VAL 8'h00
// ==========================================================
// Reset values
`define TDT_FLAG_RST 2'h0
`define TDT_LOCK_RST 2'h0
`define TDT_SYNC_RST 2'h0
`endif

// [pkg/tdt_pkg.sv]
// Types of the dual channel tamper detect block
`default_nettype none
package tdt_pkg;
  // Wipe sequencer states, one-hot
  typedef enum logic [1:0] {
    TDT_WIPE_IDLE = 2'b01,
    TDT_WIPE_RUN = 2'b10
  } tdt_wipe_t;
endpackage
`default_nettype wire

// [design/tdt_tamper_detect.sv]
// Two channel tamper detector with sticky flags, interrupt and user RAM wipe
// ==========================================================
`include "tdt_defines.svh"
`default_nettype none
module tdt_tamper_detect #(
  // Sample period in cycles; shorten for simulation
  parameter int unsigned SAMPLE_CYC = `TDT_SAMPLE_PERIOD_MS * `TDT_CLK_KHZ
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic tamper_input_one,
  input wire logic tamper_input_two,
  input wire logic tamper_arm_one,
  input wire logic tamper_arm_two,
  input wire logic tamper_irq_en_one,
  input wire logic tamper_irq_en_two,
  input wire logic switch_type_one,
  input wire logic switch_type_two,
  input wire logic trigger_level_one,
  input wire logic trigger_level_two,
  input wire logic sample_select_one,
  input wire logic sample_select_two,
  input wire logic pull_strength_one,
  input wire logic pull_strength_two,
  input wire logic ram_wipe_one,
  input wire logic ram_wipe_two,
  input wire logic alarm_in_backup_en,
  input wire logic on_battery,
  input wire logic osc_running,
  output logic tamper_flag_one,
  output logic tamper_flag_two,
  output logic tamper_irq_b,
  output logic pull_en_one,
  output logic pull_en_two,
  output logic pull_up_one,
  output logic pull_up_two,
  output logic pull_strong_one,
  output logic pull_strong_two,
  input wire logic [`TDT_RAM_AW-1:0] ram_addr,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_rd,
  output logic [7:0] ram_rdata,
  output logic ram_rvalid,
  output logic ram_locked,
  output logic ram_wiping
);

  // ==========================================================
  // Channel vectors
  logic [1:0] pin; // Raw tamper pins
  logic [1:0] arm; // Channel armed
  logic [1:0] irq_en; // Interrupt enable per channel
  logic [1:0] stype; // One is normally open
  logic [1:0] level; // Trigger level
  logic [1:0] ssel; // Sampling requested
  logic [1:0] pstr; // Strong pull requested
  logic [1:0] wipe_en; // Wipe RAM on tamper
  assign pin = {tamper_input_two, tamper_input_one};
  assign arm = {tamper_arm_two, tamper_arm_one};
  assign irq_en = {tamper_irq_en_two, tamper_irq_en_one};
  assign stype = {switch_type_two, switch_type_one};
  assign level = {trigger_level_two, trigger_level_one};
  assign ssel = {sample_select_two, sample_select_one};
  assign pstr = {pull_strength_two, pull_strength_one};
  assign wipe_en = {ram_wipe_two, ram_wipe_one};

  // ==========================================================
  // Sample timer
  logic [31:0] tick_cnt; // Cycles within one sample period
  logic [31:0] next_tick_cnt;
  logic [2:0] win_cnt; // Remaining pull window cycles
  logic [2:0] next_win_cnt;
  logic sample_win; // Pull applied for a sample
  logic sample_eval; // Last window cycle, input is judged
  // Free running period counter opens a short pull window once per period
  always_comb begin
    next_tick_cnt = tick_cnt + 32'h1;
    next_win_cnt = win_cnt;
    if (tick_cnt >= 32'(SAMPLE_CYC - 1)) begin
      // Period over, open a new window
      next_tick_cnt = 32'h0;
      next_win_cnt = `TDT_SAMPLE_WIN_CYC;
    end else if (win_cnt != 3'h0) begin
      next_win_cnt = win_cnt - 3'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= 32'h0;
      win_cnt <= 3'h0;
    end else begin
      tick_cnt <= next_tick_cnt;
      win_cnt <= next_win_cnt;
    end
  end
  assign sample_win = (win_cnt != 3'h0);
  assign sample_eval = (win_cnt == 3'h1);

  // ==========================================================
  // Per channel detection
  logic [1:0] sync_a; // First synchroniser stage, read only by sync_b
  logic [1:0] sync_b; // Second synchroniser stage
  logic [1:0] sampled; // Channel really samples
  logic [1:0] tamper_evt; // Detected tamper this cycle
  logic [1:0] flag; // Sticky tamper flags
  logic [1:0] next_flag;
  logic [1:0] lock; // RAM lock per channel
  logic [1:0] next_lock;
  logic [1:0] pull_en; // Pull enable per channel
  logic [1:0] next_pull_en;
  logic [1:0] pull_up; // Pull direction per channel
  logic [1:0] next_pull_up;
  logic [1:0] pull_strong; // Pull strength per channel
  logic [1:0] next_pull_strong;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      // Mode, event and next state of one channel
      always_comb begin
        // Sampling only for closed switches with a live oscillator
        sampled[ch] = ssel[ch] & ~stype[ch] & osc_running;
        // Pin at trigger level is a tamper for both switch types; judged per window when sampling
        tamper_evt[ch] = arm[ch] & (sync_b[ch] == level[ch]) & (~sampled[ch] | sample_eval);
        // Disarm wins; disarming is the only clear
        next_flag[ch] = arm[ch] & (flag[ch] | tamper_evt[ch]);
        next_lock[ch] = arm[ch] & (lock[ch] | (tamper_evt[ch] & wipe_en[ch]));
        // Normally closed needs the internal pull; when sampling only during the window
        next_pull_en[ch] = arm[ch] & ~stype[ch] & (~sampled[ch] | sample_win);
        next_pull_up[ch] = level[ch];
        next_pull_strong[ch] = pstr[ch] & ~stype[ch];
      end
      // Channel registers
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync_a[ch] <= 1'b0;
          sync_b[ch] <= 1'b0;
          flag[ch] <= 1'b0;
          lock[ch] <= 1'b0;
          pull_en[ch] <= 1'b0;
          pull_up[ch] <= 1'b0;
          pull_strong[ch] <= 1'b0;
        end else begin
          sync_a[ch] <= pin[ch];
          sync_b[ch] <= sync_a[ch];
          flag[ch] <= next_flag[ch];
          lock[ch] <= next_lock[ch];
          pull_en[ch] <= next_pull_en[ch];
          pull_up[ch] <= next_pull_up[ch];
          pull_strong[ch] <= next_pull_strong[ch];
        end
      end
    end
  endgenerate

  assign tamper_flag_one = flag[0];
  assign tamper_flag_two = flag[1];
  assign pull_en_one = pull_en[0];
  assign pull_en_two = pull_en[1];
  assign pull_up_one = pull_up[0];
  assign pull_up_two = pull_up[1];
  assign pull_strong_one = pull_strong[0];
  assign pull_strong_two = pull_strong[1];

  // ==========================================================
  // Interrupt output
  logic irq_b; // Registered active low interrupt
  logic next_irq_b;
  // Level interrupt follows the flags; on battery it is gated by the backup enable
  always_comb begin
    next_irq_b = ~((|(flag & irq_en)) & (~on_battery | alarm_in_backup_en));
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b <= 1'b1;
    end else begin
      irq_b <= next_irq_b;
    end
  end
  assign tamper_irq_b = irq_b;

  // ==========================================================
  // User RAM and wipe sequencer
  logic [7:0] mem [`TDT_RAM_BYTES]; // User RAM
  tdt_pkg::tdt_wipe_t wstate; // Wipe sequencer state
  tdt_pkg::tdt_wipe_t next_wstate;
  logic [`TDT_RAM_AW-1:0] wipe_addr; // Byte being wiped
  logic [`TDT_RAM_AW-1:0] next_wipe_addr;
  logic wipe_start; // A new wipe is requested
  logic mem_we; // RAM write strobe
  logic [`TDT_RAM_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [7:0] rdata;
  logic rvalid;
  assign wipe_start = |(tamper_evt & wipe_en & ~lock);
  // Wipe walks all addresses once; a wiping tamper on a channel not yet locked restarts it so no byte is missed
  always_comb begin
    next_wstate = wstate;
    next_wipe_addr = wipe_addr;
    unique case (wstate)
      tdt_pkg::TDT_WIPE_IDLE: begin
        // Wait for a wiping tamper
        if (wipe_start) begin
          next_wstate = tdt_pkg::TDT_WIPE_RUN;
          next_wipe_addr = '0;
        end
      end
      tdt_pkg::TDT_WIPE_RUN: begin
        // Zero one byte per cycle
        if (wipe_start) begin
          next_wipe_addr = '0;
        end else if (wipe_addr == `TDT_RAM_LAST) begin
          next_wstate = tdt_pkg::TDT_WIPE_IDLE;
        end else begin
          next_wipe_addr = wipe_addr + 7'h1;
        end
      end
      default: begin
        // Illegal code falls back to idle
        next_wstate = tdt_pkg::TDT_WIPE_IDLE;
      end
    endcase
  end

  // Write port: wipe has priority, user writes refused while locked
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = ram_addr;
    mem_wdata = ram_wdata;
    if (wstate == tdt_pkg::TDT_WIPE_RUN) begin
      mem_we = 1'b1;
      mem_waddr = wipe_addr;
      mem_wdata = `TDT_RAM_WIPE_VAL;
    end else if (ram_wr && !ram_locked) begin
      mem_we = 1'b1;
    end
    // Reads while locked never show the cleared contents
    next_rvalid = ram_rd;
    next_rdata = ram_locked ? `TDT_RAM_INVALID : mem[ram_addr];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wstate <= tdt_pkg::TDT_WIPE_IDLE;
      wipe_addr <= '0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      wstate <= next_wstate;
      wipe_addr <= next_wipe_addr;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // RAM cells carry no reset, as in a real macro
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign ram_locked = |lock;
  assign ram_wiping = (wstate == tdt_pkg::TDT_WIPE_RUN);
  assign ram_rdata = rdata;
  assign ram_rvalid = rvalid;

  // ==========================================================
  // Assertions
  AST_FLAG_NEEDS_ARM:
    assert property (@(posedge core_clk) disable iff (!rst_b) !tamper_arm_one |=> !tamper_flag_one)
    else $error("Flag one set while channel disarmed");
  AST_FLAG_STICKY:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      tamper_flag_two && tamper_arm_two |=> tamper_flag_two)
    else $error("Flag two dropped while armed");
  AST_FLAG_IMMEDIATE:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      tamper_arm_one && !sampled[0] && sync_b[0] == trigger_level_one |=> tamper_flag_one)
    else $error("Flag one not set one cycle after armed tamper");
  AST_SYNC_DELAY:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      rst_b |-> ##2 sync_b[1] == $past(tamper_input_two, 2))
    else $error("Input two not delayed by two flops");
  AST_IRQ_LINE:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      tamper_flag_one && tamper_irq_en_one && !on_battery |=> !tamper_irq_b)
    else $error("Interrupt not raised for flag one");
  AST_IRQ_BACKUP:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      on_battery && !alarm_in_backup_en |=> tamper_irq_b)
    else $error("Interrupt driven on battery without backup enable");
  AST_NO_SAMPLE_OPEN:
    assert property (@(posedge core_clk) disable iff (!rst_b) switch_type_two |-> !sampled[1])
    else $error("Normally open channel two is sampled");
  AST_OSC_STOP:
    assert property (@(posedge core_clk) disable iff (!rst_b) !osc_running |-> sampled == 2'b00)
    else $error("Sampling with the oscillator stopped");
  AST_PULL_OPEN:
    assert property (@(posedge core_clk) disable iff (!rst_b) switch_type_one |=> !pull_strong_one)
    else $error("Strong pull in normally open mode");
  AST_WIPE_LEN:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(ram_wiping) && !wipe_start |-> ram_wiping [*8] ##0 wipe_addr == 7'h07)
    else $error("Wipe does not walk addresses in order");
  AST_LOCKED_READ:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      ram_rd && ram_locked |=> ram_rvalid && ram_rdata == 8'hff)
    else $error("Locked read returned stored data");
  AST_SAMPLE_GATE:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      sampled[0] && !sample_eval |-> !tamper_evt[0])
    else $error("Sampled channel one judged outside its window");

endmodule
`default_nettype wire

// [dv/tdt_switch_model.sv]
// Behavioural external tamper switch driving one tamper pin
`default_nettype none
module tdt_switch_model (
  input wire logic core_clk,
  input wire logic switch_type,
  input wire logic trigger_level,
  input wire logic pull_en,
  input wire logic pull_up,
  input wire logic actuated,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Floating pin pattern, so an undriven pin never looks steady
  logic float_q = 1'b0;
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end
  // ==========
  // Pin level from switch state and internal pull
  always_comb begin
    if (switch_type) begin
      // Normally open; an external bias holds the pin off the trigger rail
      pin = actuated ? trigger_level : ~trigger_level;
    end else if (!actuated) begin
      // Closed switch holds the pin away from the trigger rail
      pin = ~trigger_level;
    end else begin
      // Opened switch: only the internal pull defines the pin
      pin = pull_en ? pull_up : float_q;
    end
  end
endmodule
`default_nettype wire

// [dv/test_tdt_tamper_detect.sv]
// Self-checking bench of the dual channel tamper detector
`default_nettype none
module test_tdt_tamper_detect;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 20; // Short sample period keeps the run brief
  // ==========
  // Signals
  logic core_clk, rst_b, pin1, pin2, act1, act2, arm1, arm2, ie1, ie2, st1, st2, lv1, lv2;
  logic ss1, ss2, ps1, ps2, wp1, wp2, abe, batt, osc, f1, f2, irq_b, pe1, pe2, pu1, pu2;
  logic ram_wr, ram_rd, rvalid, locked, wiping, p1, p2, pso1, pso2;
  logic [6:0] ram_addr;
  logic [7:0] ram_wdata, rdata, d0, d1;
  logic [9:0] notes[$]; // Expected results: kind then data
  logic [9:0] note; // Note taken by the monitor, kept apart from the stimulus data
  int n_errors, n_checks, seed;
  // ==========
  // Design and switch models
  tdt_tamper_detect #(.SAMPLE_CYC(SC)) tdt_tamper_detect_inst (.core_clk(core_clk), .rst_b(rst_b),
    .tamper_input_one(pin1), .tamper_input_two(pin2), .tamper_arm_one(arm1), .tamper_arm_two(arm2),
    .tamper_irq_en_one(ie1), .tamper_irq_en_two(ie2), .switch_type_one(st1), .switch_type_two(st2),
    .trigger_level_one(lv1), .trigger_level_two(lv2), .sample_select_one(ss1), .sample_select_two(ss2),
    .pull_strength_one(ps1), .pull_strength_two(ps2), .ram_wipe_one(wp1), .ram_wipe_two(wp2),
    .alarm_in_backup_en(abe), .on_battery(batt), .osc_running(osc), .tamper_flag_one(f1),
    .tamper_flag_two(f2), .tamper_irq_b(irq_b), .pull_en_one(pe1), .pull_en_two(pe2), .pull_up_one(pu1),
    .pull_up_two(pu2), .pull_strong_one(pso1), .pull_strong_two(pso2), .ram_addr(ram_addr), .ram_wr(ram_wr),
    .ram_wdata(ram_wdata), .ram_rd(ram_rd), .ram_rdata(rdata), .ram_rvalid(rvalid), .ram_locked(locked),
    .ram_wiping(wiping));
  tdt_switch_model sw1_inst (.core_clk(core_clk), .switch_type(st1), .trigger_level(lv1), .pull_en(pe1),
    .pull_up(pu1), .actuated(act1), .pin(pin1));
  tdt_switch_model sw2_inst (.core_clk(core_clk), .switch_type(st2), .trigger_level(lv2), .pull_en(pe2),
    .pull_up(pu2), .actuated(act2), .pin(pin2));
  // ==========
  // Clock
  always #20 core_clk = ~core_clk;
  // ==========
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
    n_checks++;
  endtask
  // One RAM access; a read leaves its expected byte as a note
  task automatic ram(input logic w, input logic [6:0] a, input logic [7:0] d);
    if (!w) notes.push_back({2'd2, d});
    ram_addr <= a;
    ram_wdata <= d;
    ram_wr <= w;
    ram_rd <= !w;
    cyc(1);
    ram_wr <= 1'b0;
    ram_rd <= 1'b0;
    cyc(2);
  endtask
  // Configure channel one while disarmed, arm it, then trip the switch
  task automatic trip1(input logic s, input logic l);
    st1 <= s;
    lv1 <= l;
    cyc(3);
    arm1 <= 1'b1;
    cyc(3);
    notes.push_back({2'd0, 8'h01});
    act1 <= 1'b1;
    cyc(6);
    act1 <= 1'b0;
    cyc(2);
  endtask
  // ==========
  // Verdict, also reached by the watchdog
  task automatic finish_test;
    if (notes.size() != 0) n_errors++;
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========
  // Monitor: each flag rise or read answer takes the oldest note
  always @(posedge core_clk) begin
    p1 <= f1;
    p2 <= f2;
    if ((f1 === 1'b1 && p1 === 1'b0) || (f2 === 1'b1 && p2 === 1'b0) || rvalid === 1'b1) begin
      if (notes.size() == 0) begin
        n_errors++;
        $display("ERROR %0t: unexpected result", $time);
      end else begin
        note = notes.pop_front();
        check({6'h0, note[9:8]}, f1 && !p1 ? 8'h00 : (f2 && !p2 ? 8'h01 : 8'h02));
        if (note[9:8] == 2'd2) check(rdata, note[7:0]);
      end
    end
  end
  // ==========
  // Watchdog against a hang
  initial begin
    cyc(3000);
    n_errors++;
    finish_test();
  end
  // ==========
  // Main sequence
  initial begin
    seed = 86;
    {core_clk, rst_b, act1, act2, arm1, arm2, ie1, ie2, st1, st2, lv1, lv2, ss1, ss2} = '0;
    {ps1, ps2, wp1, wp2, abe, batt, osc, ram_wr, ram_rd, p1, p2} = '0;
    ram_addr = 7'h00;
    ram_wdata = 8'h00;
    cyc(10);
    rst_b <= 1'b1;
    cyc(2);
    check({f1, f2, irq_b, locked, wiping}, 8'h04);
    ie1 <= 1'b1;
    // Strong pull asked for throughout, so the open modes must drop it
    ps1 <= 1'b1;
    // Every switch type and trigger level on channel one
    for (int m = 0; m < 4; m++) begin
      trip1(m[1], m[0]);
      check(f1, 1'b1);
      check(irq_b, 1'b0);
      check(pso1, !m[1]);
      check(pu1, m[0]);
      check(pe1, !m[1]);
      arm1 <= 1'b0;
      cyc(3);
      check(f1, 1'b0);
    end
    // Disarmed channel ignores a tamper
    act1 <= 1'b1;
    cyc(6);
    check(f1, 1'b0);
    act1 <= 1'b0;
    // Interrupt on battery needs the backup enable
    trip1(1'b1, 1'b1);
    batt <= 1'b1;
    cyc(3);
    check(irq_b, 1'b1);
    abe <= 1'b1;
    cyc(3);
    check(irq_b, 1'b0);
    ie1 <= 1'b0;
    cyc(3);
    check(irq_b, 1'b1);
    arm1 <= 1'b0;
    // Sampled normally closed channel two, then stopped oscillator
    {osc, ss2, ps2, arm2, ie2} <= 5'h1f;
    cyc(3);
    notes.push_back({2'd1, 8'h00});
    act2 <= 1'b1;
    cyc(2 * SC + 10);
    check(f2, 1'b1);
    check(irq_b, 1'b0);
    check(pso2, 1'b1);
    arm2 <= 1'b0;
    osc <= 1'b0;
    cyc(3);
    notes.push_back({2'd1, 8'h00});
    arm2 <= 1'b1;
    cyc(5);
    check(f2, 1'b1);
    {arm2, act2} <= 2'b00;
    // RAM traffic, then a wipe by channel one
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    ram(1'b1, 7'h00, d0);
    ram(1'b1, 7'h7f, d1);
    ram(1'b0, 7'h00, d0);
    ram(1'b0, 7'h7f, d1);
    wp1 <= 1'b1;
    trip1(1'b1, 1'b1);
    check(locked, 1'b1);
    cyc(135);
    check(wiping, 1'b0);
    ram(1'b1, 7'h00, 8'h5a);
    ram(1'b0, 7'h00, 8'hff);
    arm1 <= 1'b0;
    cyc(3);
    check(locked, 1'b0);
    ram(1'b0, 7'h00, 8'h00);
    ram(1'b0, 7'h7f, 8'h00);
    cyc(3);
    finish_test();
  end
endmodule
`default_nettype wire
